// [src/pmh_regs.svh]
`ifndef PMH_REGS_SVH
`define PMH_REGS_SVH
`define PMH_CLOCK_HZ      40000000
`define PMH_CLOCK_KHZ     40000
`define PMH_CLOCK_MHZ     40
`define PMH_MII_10_HZ     2500000
`define PMH_MII_100_HZ    25000000
`define PMH_JABBER_MS     20
`define PMH_UNJAB_MS      250
`define PMH_SQE_NS        1000
`define PMH_PREAMBLE_ONES 6'h20
`define PMH_OP_READ       2'h2
`define PMH_OP_WRITE      2'h1
`define PMH_BCAST_ADDR    3'h0
`define PMH_MII_CONFIG    3'h0
`define PMH_REG_CTRL      5'h00
`define PMH_REG_STATUS    5'h01
`define PMH_REG_ID1       5'h02
`define PMH_REG_ID2       5'h03
`define PMH_REG_ADV       5'h04
`define PMH_REG_LPA       5'h05
`define PMH_REG_ANEXP     5'h06
`define PMH_REG_IRQ       5'h1b
`define PMH_REG_SPECIAL   5'h1f
`define PMH_STAT_LINK_BIT 2
`define PMH_POL_BIT       9
`define PMH_IRQ_LINK_UP   0
`define PMH_IRQ_RX_ERR    1
`define PMH_IRQ_LINK_DOWN 2
`define PMH_IRQ_JABBER    3
`define PMH_RESET_REG     16'h0000
`endif

// [src/pmh_pkg.sv]
package pmh_pkg;
  // line symbol classes delivered by the line core
  typedef enum logic [2:0] {
    CODE_DATA = 3'h0, CODE_PRE = 3'h1, CODE_SFD = 3'h2, CODE_JK = 3'h3,
    CODE_TR = 3'h4, CODE_IDLE = 3'h5, CODE_ERR = 3'h6, CODE_EOF = 3'h7
  } pmh_code_type;
  // management frame states, one-hot
  typedef enum logic [6:0] {
    MG_PRE = 7'h01, MG_START = 7'h02, MG_OP = 7'h04, MG_PHY = 7'h08,
    MG_REG = 7'h10, MG_TA = 7'h20, MG_DATA = 7'h40
  } pmh_mgmt_type;
endpackage

// [src/pmh_stream_if.sv]
`timescale 1ns/1ps
interface pmh_stream_if #(parameter int W = 7) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// [src/pmh_sync.sv]
`timescale 1ns/1ps
module pmh_sync #(parameter int W = 1) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // two flops; only the second reads the first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pmh_sync

// [src/pmh_fifo.sv]
`timescale 1ns/1ps
module pmh_fifo #(parameter int W = 7, parameter int DEPTH = 4) (
  input  wire logic   clk,
  input  wire logic   arst_n,
  pmh_stream_if.sink   in_s,
  pmh_stream_if.source out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [W-1:0]  mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0]   count, next_count;
  logic          push, pop;

  assign push = in_s.valid & in_s.ready;
  assign pop  = out_s.valid & out_s.ready;
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);

  // storage written only on accepted words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // pointers and a registered ready, so full is exact
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_s.ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + AW'(1);
      end
      count      <= next_count;
      in_s.ready <= (next_count != FULL);
    end
  end
endmodule // pmh_fifo

// [src/pmh_mii_phy.sv]
`timescale 1ns/1ps
`include "pmh_regs.svh"
module pmh_mii_phy #(
  parameter int unsigned JABBER_CYCLES = `PMH_JABBER_MS * `PMH_CLOCK_KHZ,
  parameter int unsigned UNJAB_CYCLES  = `PMH_UNJAB_MS * `PMH_CLOCK_KHZ,
  parameter logic [15:0] ID1_VALUE     = 16'h0000, // arbitrary
  parameter logic [15:0] ID2_VALUE     = 16'h0000, // arbitrary
  parameter int          FIFO_DEPTH    = 4
) (
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  input  wire logic [2:0] DEVICE_ADDR_STRAPS,
  input  wire logic [2:0] CONFIG_STRAPS,
  input  wire logic       MDC,
  input  wire logic       MDIO_IN,
  output logic            MDIO_OUT,
  output logic            MDIO_OE,
  output logic            STATUS_CHANGE_IRQ,
  output logic            TXC,
  input  wire logic       TXEN,
  input  wire logic [3:0] TXD,
  output logic            RXC,
  output logic            RXDV,
  output logic      [3:0] RXD,
  output logic            RXER,
  output logic            CRS,
  output logic            COL,
  output logic            RXC_FROM_LINE,
  input  wire logic       LINK_UP,
  input  wire logic       SPEED_100,
  input  wire logic       FULL_DUPLEX,
  input  wire logic       LINE_VALID,
  input  wire logic [2:0] LINE_CODE,
  input  wire logic [3:0] LINE_NIBBLE,
  output logic            LINE_READY,
  output logic            TX_NIBBLE_VALID,
  output logic      [3:0] TX_NIBBLE,
  output logic            TX_ENABLE_LINE
);
  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int unsigned H10 = `PMH_CLOCK_HZ / (2 * `PMH_MII_10_HZ);
  localparam int unsigned H100 = `PMH_CLOCK_HZ / (2 * `PMH_MII_100_HZ);
  localparam logic [7:0] HALF_10  = 8'((H10 < 1) ? 1 : H10);
  localparam logic [7:0] HALF_100 = 8'((H100 < 1) ? 1 : H100);
  localparam int unsigned SQE_N =
    (`PMH_SQE_NS * `PMH_CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] SQE_CYCLES = 8'((SQE_N < 1) ? 1 : SQE_N);
  localparam logic [23:0] JAB_LIM   = 24'(JABBER_CYCLES);
  localparam logic [23:0] UNJAB_LIM = 24'(UNJAB_CYCLES);

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [2:0] addr_s, cfg_s;
  logic       mdc_s, mdio_s, txen_s;
  logic [3:0] txd_s;
  pmh_sync #(.W(6)) u_strap_sync (
    .clk(CLOCK), .arst_n(ARST_N),
    .d({DEVICE_ADDR_STRAPS, CONFIG_STRAPS}), .q({addr_s, cfg_s}));
  pmh_sync #(.W(7)) u_pin_sync (
    .clk(CLOCK), .arst_n(ARST_N),
    .d({MDC, MDIO_IN, TXEN, TXD}), .q({mdc_s, mdio_s, txen_s, txd_s}));

  // ----------------------------------------------------------
  // straps, caught once after reset release
  // ----------------------------------------------------------
  logic [1:0] strap_wait;
  logic [2:0] my_addr;
  logic       mii_mode;
  // wait until the synchroniser holds the real pin level
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_wait <= 2'h0;
      my_addr    <= 3'h0;
      mii_mode   <= 1'b0;
    end else if (strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        my_addr  <= addr_s;
        mii_mode <= (cfg_s == `PMH_MII_CONFIG);
      end
    end
  end

  // ----------------------------------------------------------
  // nibble clock divider, shared by transmit and receive
  // ----------------------------------------------------------
  logic [7:0] div_cnt;
  logic [7:0] half;
  logic       tick, rise;
  logic [2:0] rise_pipe;
  assign half = SPEED_100 ? HALF_100 : HALF_10;
  assign tick = (div_cnt >= half - 8'h01);
  assign rise = tick & ~TXC;
  // free running: the mac needs transmit clock even when idle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt   <= 8'h00;
      TXC       <= 1'b0;
      RXC       <= 1'b0;
      rise_pipe <= 3'h0;
    end else begin
      div_cnt   <= tick ? 8'h00 : div_cnt + 8'h01;
      TXC       <= tick ? ~TXC : TXC;
      RXC       <= tick ? ~TXC : TXC;
      rise_pipe <= {rise_pipe[1:0], rise};
    end
  end

  // ----------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------
  logic        take, tx_act, jabbered;
  logic [23:0] jab_cnt;
  logic [7:0]  sqe_cnt;
  // sampled three cycles after the edge: two sync flops plus
  // the mac output delay, so every nibble is caught once
  assign take = rise_pipe[2];
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_act          <= 1'b0;
      TX_NIBBLE_VALID <= 1'b0;
      TX_NIBBLE       <= 4'h0;
    end else begin
      TX_NIBBLE_VALID <= 1'b0;
      if (take) begin
        tx_act <= txen_s;
        if (txen_s && mii_mode && !jabbered) begin
          TX_NIBBLE_VALID <= 1'b1;
          TX_NIBBLE       <= txd_s;
        end
      end
    end
  end

  // jabber guard and quality pulse, only at 10M
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      jab_cnt  <= 24'h00_0000;
      jabbered <= 1'b0;
      sqe_cnt  <= 8'h00;
    end else begin
      if (SPEED_100) begin
        jab_cnt  <= 24'h00_0000;
        jabbered <= 1'b0;
      end else if (!jabbered) begin
        jab_cnt <= tx_act ? jab_cnt + 24'h00_0001 : 24'h00_0000;
        if (tx_act && jab_cnt >= JAB_LIM) begin
          jabbered <= 1'b1;
          jab_cnt  <= 24'h00_0000;
        end
      end else begin
        jab_cnt <= tx_act ? 24'h00_0000 : jab_cnt + 24'h00_0001;
        if (!tx_act && jab_cnt >= UNJAB_LIM) begin
          jabbered <= 1'b0;
          jab_cnt  <= 24'h00_0000;
        end
      end
      if (take && tx_act && !txen_s && !SPEED_100) begin
        sqe_cnt <= SQE_CYCLES;
      end else if (sqe_cnt != 8'h00) begin
        sqe_cnt <= sqe_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------
  // receive path: line symbols buffered, drained per rx clock
  // ----------------------------------------------------------
  pmh_stream_if #(.W(7)) fill_if ();
  pmh_stream_if #(.W(7)) drain_if ();
  assign fill_if.valid = LINE_VALID;
  assign fill_if.data  = {LINE_CODE, LINE_NIBBLE};
  assign LINE_READY    = fill_if.ready;
  assign drain_if.ready = rise;
  pmh_fifo #(.W(7), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(CLOCK), .arst_n(ARST_N), .in_s(fill_if), .out_s(drain_if));

  pmh_pkg::pmh_code_type in_code, out_code;
  logic in_acc;
  assign in_code  = pmh_pkg::pmh_code_type'(LINE_CODE);
  assign out_code = pmh_pkg::pmh_code_type'(drain_if.data[6:4]);
  assign in_acc   = LINE_VALID & fill_if.ready;

  // carrier follows symbols as they arrive from the line
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      CRS <= 1'b0;
    end else if (!LINK_UP || !mii_mode) begin
      CRS <= 1'b0;
    end else if (in_acc) begin
      if (!SPEED_100) begin
        if (in_code == pmh_pkg::CODE_PRE) begin
          CRS <= 1'b1;
        end else if (in_code == pmh_pkg::CODE_EOF) begin
          CRS <= 1'b0;
        end
      end else begin
        if (in_code == pmh_pkg::CODE_JK) begin
          CRS <= 1'b1;
        end else if (in_code == pmh_pkg::CODE_TR) begin
          CRS <= 1'b0;
        end else if (in_code == pmh_pkg::CODE_IDLE) begin
          CRS <= 1'b0;
        end
      end
    end
  end

  // receive outputs change only with the rising rx clock
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RXDV <= 1'b0;
      RXD  <= 4'h0;
      RXER <= 1'b0;
    end else if (rise) begin
      RXER <= 1'b0;
      if (!mii_mode) begin
        RXDV <= 1'b0;
        RXD  <= 4'h0;
      end else if (drain_if.valid) begin
        case (out_code)
          pmh_pkg::CODE_PRE, pmh_pkg::CODE_JK: begin
            if (SPEED_100 || RXDV) begin
              RXDV <= 1'b1;
              RXD  <= drain_if.data[3:0];
            end
          end
          pmh_pkg::CODE_SFD: begin
            RXDV <= 1'b1;
            RXD  <= drain_if.data[3:0];
          end
          pmh_pkg::CODE_DATA: begin
            RXD <= RXDV ? drain_if.data[3:0] : 4'h0;
          end
          pmh_pkg::CODE_ERR: begin
            RXER <= RXDV;
            RXD  <= RXDV ? drain_if.data[3:0] : 4'h0;
          end
          default: begin
            RXDV <= 1'b0;
            RXD  <= 4'h0;
          end
        endcase
      end
    end
  end

  // clock source flag and collision
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RXC_FROM_LINE  <= 1'b0;
      COL            <= 1'b0;
      TX_ENABLE_LINE <= 1'b0;
    end else begin
      RXC_FROM_LINE  <= LINK_UP & (SPEED_100 | CRS);
      COL <= jabbered | (sqe_cnt != 8'h00) |
             (!FULL_DUPLEX & tx_act & CRS);
      TX_ENABLE_LINE <= mii_mode & ~jabbered;
    end
  end

  // ----------------------------------------------------------
  // management frame engine
  // ----------------------------------------------------------
  pmh_pkg::pmh_mgmt_type state;
  logic        mdc_d, mdc_rise, hit, rd_clr, wr_go;
  logic [5:0]  ones;
  logic [4:0]  cnt, reg_a, shift_in5;
  logic [1:0]  op;
  logic [15:0] sh, rd_sh, wr_data;
  logic [15:0] wr_reg [0:3];
  logic [15:0] special, irq_reg;
  logic [7:0]  irq_ev, irq_en, irq_stat;
  logic        link_d;

  // read value of every mapped register; others read zero
  function automatic logic [15:0] reg_value(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `PMH_REG_CTRL:   v = wr_reg[0];
      `PMH_REG_STATUS: v[`PMH_STAT_LINK_BIT] = LINK_UP;
      `PMH_REG_ID1:    v = ID1_VALUE;
      `PMH_REG_ID2:    v = ID2_VALUE;
      `PMH_REG_ADV:    v = wr_reg[1];
      `PMH_REG_LPA:    v = wr_reg[2];
      `PMH_REG_ANEXP:  v = wr_reg[3];
      `PMH_REG_IRQ:    v = irq_reg;
      `PMH_REG_SPECIAL: v = special;
      default:         v = 16'h0000;
    endcase
    return v;
  endfunction

  assign mdc_rise  = mdc_s & ~mdc_d;
  assign shift_in5 = {sh[3:0], mdio_s};
  assign rd_clr = mdc_rise && state == pmh_pkg::MG_REG &&
                  cnt == 5'h04 && op == `PMH_OP_READ && hit &&
                  shift_in5 == `PMH_REG_IRQ;
  assign wr_go  = mdc_rise && state == pmh_pkg::MG_DATA &&
                  cnt == 5'h0f && op == `PMH_OP_WRITE && hit;
  assign wr_data = {sh[14:0], mdio_s};
  // enable and status halves each kept by one process
  assign irq_reg = {irq_en, irq_stat};

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mdc_d <= 1'b0;
    end else begin
      mdc_d <= mdc_s;
    end
  end

  // frame parser; the line is driven only for matching reads
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state    <= pmh_pkg::MG_PRE;
      ones     <= 6'h00;
      cnt      <= 5'h00;
      sh       <= 16'h0000;
      op       <= 2'h0;
      hit      <= 1'b0;
      reg_a    <= 5'h00;
      rd_sh    <= 16'h0000;
      MDIO_OUT <= 1'b0;
      MDIO_OE  <= 1'b0;
    end else if (mdc_rise) begin
      sh <= {sh[14:0], mdio_s};
      case (state)
        pmh_pkg::MG_PRE: begin
          if (mdio_s) begin
            if (ones != `PMH_PREAMBLE_ONES) begin
              ones <= ones + 6'h01;
            end
          end else if (ones == `PMH_PREAMBLE_ONES) begin
            state <= pmh_pkg::MG_START;
          end else begin
            ones <= 6'h00;
          end
        end
        pmh_pkg::MG_START: begin
          ones  <= 6'h00;
          cnt   <= 5'h00;
          state <= mdio_s ? pmh_pkg::MG_OP : pmh_pkg::MG_PRE;
        end
        pmh_pkg::MG_OP: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h01) begin
            op    <= {sh[0], mdio_s};
            cnt   <= 5'h00;
            state <= pmh_pkg::MG_PHY;
          end
        end
        pmh_pkg::MG_PHY: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h04) begin
            hit <= shift_in5[4:3] == 2'h0 &&
                   (shift_in5[2:0] == my_addr ||
                    shift_in5[2:0] == `PMH_BCAST_ADDR);
            cnt   <= 5'h00;
            state <= pmh_pkg::MG_REG;
          end
        end
        pmh_pkg::MG_REG: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h04) begin
            reg_a <= shift_in5;
            rd_sh <= reg_value(shift_in5);
            cnt   <= 5'h00;
            state <= pmh_pkg::MG_TA;
          end
        end
        pmh_pkg::MG_TA: begin
          if (cnt == 5'h00) begin
            cnt <= 5'h01;
            if (op == `PMH_OP_READ && hit) begin
              MDIO_OE  <= 1'b1;
              MDIO_OUT <= 1'b0;
            end
          end else begin
            cnt   <= 5'h00;
            state <= pmh_pkg::MG_DATA;
            if (op == `PMH_OP_READ && hit) begin
              MDIO_OUT <= rd_sh[15];
              rd_sh    <= {rd_sh[14:0], 1'b0};
            end
          end
        end
        pmh_pkg::MG_DATA: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h0f) begin
            cnt      <= 5'h00;
            state    <= pmh_pkg::MG_PRE;
            MDIO_OE  <= 1'b0;
            MDIO_OUT <= 1'b0;
          end else if (op == `PMH_OP_READ && hit) begin
            MDIO_OUT <= rd_sh[15];
            rd_sh    <= {rd_sh[14:0], 1'b0};
          end
        end
        default: begin
          state <= pmh_pkg::MG_PRE;
          ones  <= 6'h00;
        end
      endcase
    end
  end

  // writable registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 4; i++) begin
        wr_reg[i] <= `PMH_RESET_REG;
      end
      special       <= `PMH_RESET_REG;
      irq_en        <= 8'h00;
    end else if (wr_go) begin
      case (reg_a)
        `PMH_REG_CTRL:    wr_reg[0] <= wr_data;
        `PMH_REG_ADV:     wr_reg[1] <= wr_data;
        `PMH_REG_LPA:     wr_reg[2] <= wr_data;
        `PMH_REG_ANEXP:   wr_reg[3] <= wr_data;
        `PMH_REG_IRQ:     irq_en <= wr_data[15:8];
        `PMH_REG_SPECIAL: special <= wr_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // status change events; a new event beats a read clear
  // ----------------------------------------------------------
  always_comb begin
    irq_ev = 8'h00;
    irq_ev[`PMH_IRQ_LINK_UP]   = LINK_UP & ~link_d;
    irq_ev[`PMH_IRQ_LINK_DOWN] = ~LINK_UP & link_d;
    irq_ev[`PMH_IRQ_RX_ERR]    = rise & RXER;
    irq_ev[`PMH_IRQ_JABBER]    = jabbered & ~COL;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      link_d            <= 1'b0;
      irq_stat          <= 8'h00;
      STATUS_CHANGE_IRQ <= 1'b0;
    end else begin
      link_d   <= LINK_UP;
      irq_stat <= irq_ev | (irq_stat & ~{8{rd_clr}});
      // polarity bit set means active high: pending xnor polarity
      STATUS_CHANGE_IRQ <= special[`PMH_POL_BIT] ~^
                           (|(irq_en & irq_stat));
    end
  end
endmodule // pmh_mii_phy

// [testbench/pmh_assertions.sv]
`timescale 1ns/1ps
// ----
// port checks
// ----
module pmh_checker (
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  input wire logic       SPEED_100,
  input wire logic       TXC,
  input wire logic       RXC,
  input wire logic       RXDV,
  input wire logic [3:0] RXD,
  input wire logic       MDIO_OE,
  input wire logic       MDIO_OUT,
  input wire logic       TX_NIBBLE_VALID,
  input wire logic       TX_ENABLE_LINE,
  input wire logic       COL
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // slow clock: eight cycles high, then low
  AST_TXC_HALF: assert property ($rose(TXC) && !SPEED_100 |->
    TXC[*8] ##1 !TXC) else $error("txc half period wrong");
  AST_RXC_PHASE: assert property (RXC == TXC)
    else $error("rxc off txc");
  AST_RXDV_EDGE: assert property ($changed(RXDV) |-> $rose(RXC))
    else $error("rxdv moved off rxc");
  AST_RXD_EDGE: assert property ($changed(RXD) |-> $rose(RXC))
    else $error("rxd moved off rxc");
  // turnaround zero stands while mdc is still synchronising
  AST_TA_ZERO: assert property ($rose(MDIO_OE) |->
    (MDIO_OE && !MDIO_OUT)[*4]) else $error("turnaround not zero");
  AST_TX_ONLY_EN: assert property (
    TX_NIBBLE_VALID |-> TX_ENABLE_LINE) else $error("nibble while disabled");
  AST_TX_PULSE: assert property (
    TX_NIBBLE_VALID |=> !TX_NIBBLE_VALID) else $error("nibble pulse too long");
  AST_JAB_COL: assert property (
    $fell(TX_ENABLE_LINE) |-> ##[0:2] COL) else $error("jabber without col");
  cover property ($rose(MDIO_OE));
  cover property ($rose(RXDV));
  cover property ($fell(TX_ENABLE_LINE));
  cover property (SPEED_100 && $rose(RXDV));
endmodule // pmh_checker

bind pmh_mii_phy pmh_checker u_chk (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .SPEED_100(SPEED_100), .TXC(TXC), .RXC(RXC), .RXDV(RXDV), .RXD(RXD),
  .MDIO_OE(MDIO_OE), .MDIO_OUT(MDIO_OUT), .COL(COL),
  .TX_NIBBLE_VALID(TX_NIBBLE_VALID), .TX_ENABLE_LINE(TX_ENABLE_LINE));

// [testbench/pmh_mgmt_model.sv]
`timescale 1ns/1ps
// ----
// management controller
// ----
module pmh_mgmt_model (
  output logic      MDC,
  output logic      M_OE,
  output logic      M_OUT,
  input  wire logic MDIO
);
  // clock stands low outside frames
  initial begin
    MDC = 1'b0;
    M_OE = 1'b0;
    M_OUT = 1'b1;
  end
  // one frame msb first; data changes well after each rising edge
  task automatic xfer(input logic [1:0] op, input logic [2:0] phy,
                      input logic [4:0] rg, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'h1, op, 2'h0, phy, rg, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      M_OE = !(op == 2'h2 && i < 18);
      M_OUT = bits[i];
      #90 MDC = 1'b1;
      if (i < 16) rd[i] = MDIO;
      #100 MDC = 1'b0;
      #10;
    end
    M_OE = 1'b0;
  endtask
endmodule // pmh_mgmt_model

// [testbench/tb.sv]
`timescale 1ns/1ps
// ----
// bench
// ----
module tb;
  logic clock = 1'b0, arst_n = 1'b0, txen = 1'b0, link_up = 1'b0;
  logic lv = 1'b0, saw_full = 1'b0, saw_crs = 1'b0, saw_er = 1'b0;
  logic saw_col = 1'b0, spd = 1'b0, fdx = 1'b0;
  logic [3:0] txd = 4'h0, ln = 4'h0, rxd, tnb;
  logic [2:0] lc = 3'h0;
  logic mdc, m_oe, m_out, mdio_out, mdio_oe, irq, rxc, rxdv, col, lrdy, txe;
  logic tnv, txc, rxer, crs, rfl;
  logic [15:0] rd;
  logic [3:0] rxq[$];
  logic [2:0] lcs[10] = '{1, 1, 2, 0, 0, 0, 0, 0, 0, 7};
  logic [3:0] lns[10] = '{5, 5, 5, 13, 3, 9, 10, 12, 6, 0};
  // fast frame: start pair, preamble, delimiter, data, error, data, end
  logic [2:0] lch[7] = '{3, 1, 2, 0, 6, 0, 4};
  logic [3:0] lnh[7] = '{5, 5, 5, 13, 7, 2, 0};
  int n_errors = 0, compares = 0, cyc = 0, n_tx = 0;
  wire mdio = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1); // pull-up
  pmh_mii_phy #(.JABBER_CYCLES(200), .UNJAB_CYCLES(500)) u_dut (
    .CLOCK(clock), .ARST_N(arst_n), .DEVICE_ADDR_STRAPS(3'h5),
    .CONFIG_STRAPS(3'h0), .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_out),
    .MDIO_OE(mdio_oe), .STATUS_CHANGE_IRQ(irq), .TXC(txc), .TXEN(txen),
    .TXD(txd), .RXC(rxc), .RXDV(rxdv), .RXD(rxd), .RXER(rxer), .CRS(crs),
    .COL(col), .RXC_FROM_LINE(rfl), .LINK_UP(link_up), .SPEED_100(spd),
    .FULL_DUPLEX(fdx), .LINE_VALID(lv), .LINE_CODE(lc), .LINE_NIBBLE(ln),
    .LINE_READY(lrdy), .TX_NIBBLE_VALID(tnv), .TX_NIBBLE(tnb),
    .TX_ENABLE_LINE(txe));
  pmh_mgmt_model u_mgmt (.MDC(mdc), .M_OE(m_oe), .M_OUT(m_out), .MDIO(mdio));
  always #12.5 clock = ~clock;
  // cycle count, taken nibbles and hang guard
  always @(posedge clock) begin
    cyc++;
    if (tnv === 1'b1) begin
      n_tx++;
      check(tnb === txd, "tx nibble");
    end
    if (crs === 1'b1) saw_crs = 1'b1;
    if (rxer === 1'b1) saw_er = 1'b1;
    if (crs === 1'b1 && col === 1'b1) saw_col = 1'b1;
    if (cyc == 15000) begin
      n_errors++;
      stop_test();
    end
  end
  // nibbles seen by the mac, sampled once settled
  always @(posedge rxc) #2 if (rxdv === 1'b1) rxq.push_back(rxd);
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [4:0] r,
                        input logic [15:0] e);
    u_mgmt.xfer(2'h2, a, r, 16'h0000, rd);
    check(rd === e, "read data");
  endtask
  // line core push; waits while the fifo refuses
  task automatic push(input logic [2:0] c, input logic [3:0] n);
    lv = 1'b1;
    lc = c;
    ln = n;
    while (lrdy !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge clock) #1;
    end
    @(posedge clock) #1;
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (6) @(posedge clock);
    rd_reg(3'h5, 5'h1b, 16'h0000);
    u_mgmt.xfer(2'h1, 3'h0, 5'h1b, 16'h0100, rd);
    rd_reg(3'h5, 5'h1b, 16'h0100);
    check(irq === 1'b1, "irq idle");
    @(posedge clock) #1 link_up = 1'b1;
    repeat (4) @(posedge clock);
    check(irq === 1'b0, "irq missing");
    rd_reg(3'h5, 5'h1b, 16'h0101);
    rd_reg(3'h5, 5'h1b, 16'h0100);
    check(irq === 1'b1, "irq stuck");
    u_mgmt.xfer(2'h1, 3'h5, 5'h1f, 16'h0200, rd);
    repeat (4) @(posedge clock);
    check(irq === 1'b0, "polarity");
    rd_reg(3'h3, 5'h1f, 16'hFFFF);
    $display("management test done");
    @(posedge clock) #1 txd = 4'hF;
    repeat (100) @(posedge clock);
    check(n_tx == 0, "idle nibble taken");
    #1 txen = 1'b1;
    repeat (300) @(posedge clock);
    #1 check(n_tx > 0 && col === 1'b1 && txe === 1'b0, "jabber");
    txen = 1'b0;
    repeat (600) @(posedge clock);
    #1 check(col === 1'b0 && txe === 1'b1, "unjab");
    check(rfl === 1'b0, "rx clock source idle");
    txen = 1'b1;
    repeat (50) @(posedge clock);
    #1 txen = 1'b0;
    repeat (30) @(posedge clock);
    #1 check(col === 1'b1, "quality pulse");
    repeat (40) @(posedge clock);
    $display("transmit test done");
    foreach (lcs[i]) push(lcs[i], lns[i]);
    lv = 1'b0;
    repeat (300) @(posedge clock);
    check(saw_full === 1'b1, "fifo never full");
    check(saw_crs === 1'b1 && crs === 1'b0, "carrier");
    check(rxq.size() == 7, "frame length");
    foreach (rxq[i]) check(rxq[i] === lns[i + 2], "rx nibble");
    $display("receive test done");
    rxq.delete();
    // switch speed just after a fall so no high half period is cut short
    @(negedge txc) #1 spd = 1'b1;
    txen = 1'b1;
    repeat (4) @(posedge clock);
    #1 check(rfl === 1'b1, "rx clock source fast");
    foreach (lch[i]) push(lch[i], lnh[i]);
    lv = 1'b0;
    txen = 1'b0;
    repeat (40) @(posedge clock);
    check(saw_col === 1'b1, "no collision");
    check(saw_er === 1'b1, "no receive error");
    check(crs === 1'b0, "carrier stuck");
    check(rxq.size() == 6, "fast frame length");
    foreach (rxq[i]) check(rxq[i] === lnh[i], "fast nibble");
    rd_reg(3'h5, 5'h1b, 16'h010A);
    $display("fast receive test done");
    stop_test();
  end
endmodule // tb
